// *** logic/dac_ctrl_pkg.sv ***
// Shared constants and types for the dual DAC serial front end.
package dac_ctrl_pkg;
   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int LATCH_BITS = 12;
   localparam int CODE_BITS = 10;
   localparam int BIT_LATCH_A = 15;
   localparam int BIT_SPEED = 14;
   localparam int BIT_POWER_DOWN = 13;
   localparam int BIT_DBUF_ONLY = 12;
   localparam int CODE_MSB = 11;
   localparam int CODE_LSB = 2;
   localparam int DAC_COUNT = 2;
   localparam logic [LATCH_BITS-1:0] LATCH_RESET = 12'h000;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
   // ------------------------------------------------------------
   // Bit counting
   // ------------------------------------------------------------
   localparam int COUNT_BITS = 5;
   localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 5'h00;
   localparam logic [COUNT_BITS-1:0] COUNT_ONE = 5'h01;
   localparam logic [COUNT_BITS-1:0] WORD_LEN = 5'h10;
   localparam logic [COUNT_BITS-1:0] COUNT_MAX = 5'h1f;
   // ------------------------------------------------------------
   // Settling times
   // ------------------------------------------------------------
   localparam real CLK_FREQ_MHZ = 100.0;
   localparam real SETTLE_SLOW_US = 12.5;
   localparam real SETTLE_FAST_US = 2.5;
   localparam int SETTLE_BITS = 11;
   localparam logic [SETTLE_BITS-1:0] SETTLE_SLOW_CYCLES =
      SETTLE_BITS'($rtoi($ceil(SETTLE_SLOW_US * CLK_FREQ_MHZ)));
   localparam logic [SETTLE_BITS-1:0] SETTLE_FAST_CYCLES =
      SETTLE_BITS'($rtoi($ceil(SETTLE_FAST_US * CLK_FREQ_MHZ)));
   localparam logic [SETTLE_BITS-1:0] SETTLE_ZERO = 11'h000;
   localparam logic [SETTLE_BITS-1:0] SETTLE_STEP = 11'h001;
   // ------------------------------------------------------------
   // Frame tracking
   // ------------------------------------------------------------
   typedef enum logic [1:0] {FRAME_IDLE, FRAME_OPEN, FRAME_ENDED} frame_state_t;
endpackage

// *** logic/update_if.sv ***
// Update strobe and word from the frame logic to the latch bank.
`timescale 1ns/1ns
interface update_if import dac_ctrl_pkg::*; ();
   logic strobe;
   logic [WORD_BITS-1:0] word;
   logic load_a;
   logic load_b;
   modport source
   (
      output strobe,
      output word,
      input load_a,
      input load_b
   );
   modport sink
   (
      input strobe,
      input word,
      output load_a,
      output load_b
   );
endinterface

// *** logic/sync2.sv ***
// Two flip-flop level synchroniser, one per bit.
`timescale 1ns/1ns
module sync2
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   // System
   input wire logic clk,
   input wire logic rst,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// *** logic/dac_latch_bank.sv ***
// Latch A, latch B and the double buffer with their transfer decode.
`timescale 1ns/1ns
module dac_latch_bank
   import dac_ctrl_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst,
   // Update from the frame logic
   update_if.sink upd,
   // Latch contents
   output logic [LATCH_BITS-1:0] latch_a,
   output logic [LATCH_BITS-1:0] latch_b,
   output logic [LATCH_BITS-1:0] dbuf
);
   logic load_dbuf;
   logic load_b_word;
   logic [LATCH_BITS-1:0] word_latch;

   assign word_latch = upd.word[CODE_MSB:0];
   assign upd.load_a = upd.strobe & upd.word[BIT_LATCH_A];
   assign load_b_word = upd.strobe & ~upd.word[BIT_LATCH_A] & ~upd.word[BIT_DBUF_ONLY];
   assign load_dbuf = upd.strobe & ~upd.word[BIT_LATCH_A];
   assign upd.load_b = upd.load_a | load_b_word;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         latch_a <= LATCH_RESET;
         latch_b <= LATCH_RESET;
         dbuf <= LATCH_RESET;
      end
      else
      begin
         if (upd.load_a)
         begin
            latch_a <= word_latch;
         end
         if (upd.load_a)
         begin
            latch_b <= dbuf;
         end
         else if (load_b_word)
         begin
            latch_b <= word_latch;
         end
         if (load_dbuf)
         begin
            dbuf <= word_latch;
         end
      end
   end
endmodule

// *** logic/dual_dac_serial_latch_control.sv ***
// Serial capture, domain crossing and output control of the dual DAC front end.
`timescale 1ns/1ns
// What this block does
// - At reset latches A, B and the double buffer all clear to zero.
// - Each DAC code is straight binary, taken from latch bits eleven down to two.
// - Every latch holds twelve bits: the code plus two ignored sub-LSB bits.
// - Word bit 14 high selects slow settling, low selects fast settling.
// - Bits 15 and 12 steer transfers; bit 13 high powers the outputs down.
// - While select is low, data shifts into a sixteen-bit register, MSB first.
// - Data is sampled and shifted on each falling serial clock edge.
// - Select rising performs the chosen transfer without any further serial clocks.
// - Program bits sit at 15..12, code at 11..2, ignored bits at 1..0.
// - Bit 15 high loads latch A and copies the double buffer into latch B.
// - Bits 15 and 12 low load latch B and the double buffer.
// - Bit 15 low, bit 12 high loads only the double buffer.
// - Latch B equals the buffer unless the last B-side write was buffer-only.
// - Self-terminating mode stops after sixteen clocks and updates, or earlier on select.
module dual_dac_serial_latch_control
   import dac_ctrl_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   // Configuration
   input wire logic self_terminate,
   // DAC drive
   output logic [CODE_BITS-1:0] dac_a_code,
   output logic [CODE_BITS-1:0] dac_b_code,
   output logic [CODE_BITS-1:0] buffer_code,
   output logic slow_mode,
   output logic power_down,
   // Status
   output logic settling_a,
   output logic settling_b,
   output logic update_done,
   output logic length_error,
   output logic [WORD_BITS-1:0] last_word
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic term_meta;
   logic term_en;
   logic frame_clear;
   logic armed;
   logic accept;
   logic shift_en;
   logic [COUNT_BITS-1:0] bit_count;
   logic [COUNT_BITS-1:0] next_bit_count;
   logic [WORD_BITS-1:0] serial_input_register;
   logic term_toggle;
   logic cs_sync;
   logic toggle_sync;
   logic cs_prev;
   logic toggle_prev;
   logic cs_rise;
   logic cs_fall;
   logic term_event;
   frame_state_t state;
   frame_state_t next_state;
   logic end_event;
   logic [WORD_BITS-1:0] word_q;
   logic [COUNT_BITS-1:0] count_q;
   logic issue;
   logic [LATCH_BITS-1:0] latch_a;
   logic [LATCH_BITS-1:0] latch_b;
   logic [LATCH_BITS-1:0] dbuf;
   logic [DAC_COUNT-1:0] load_ch;
   logic [SETTLE_BITS-1:0] settle_cnt [DAC_COUNT];

   update_if upd();

   // ------------------------------------------------------------
   // Link domain: mode strap
   // ------------------------------------------------------------
   // The serial clock stops between frames, so the strap may need a few
   // clocks of a frame before a change of mode takes effect.
   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
      begin
         term_meta <= 1'b0;
         term_en <= 1'b0;
      end
      else
      begin
         term_meta <= self_terminate;
         term_en <= term_meta;
      end
   end

   // ------------------------------------------------------------
   // Link domain: frame start
   // ------------------------------------------------------------
   // Select high rearms the frame asynchronously, because no serial clock
   // edge can be counted on between frames.
   assign frame_clear = rst | cs_n;

   always_ff @(negedge sclk or posedge frame_clear)
   begin
      if (frame_clear)
      begin
         armed <= 1'b1;
      end
      else
      begin
         armed <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Link domain: bit counter
   // ------------------------------------------------------------
   // stop after sixteen
   assign accept = armed | ~(term_en & (bit_count == WORD_LEN));
   assign shift_en = ~cs_n & accept;

   always_comb
   begin
      if (armed)
      begin
         next_bit_count = COUNT_ONE;
      end
      else if (bit_count == COUNT_MAX)
      begin
         next_bit_count = COUNT_MAX;
      end
      else
      begin
         next_bit_count = bit_count + COUNT_ONE;
      end
   end

   // The count is not cleared by select, so the frame logic can still read
   // the length of the frame after select has risen.
   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
      begin
         bit_count <= COUNT_ZERO;
      end
      else if (shift_en)
      begin
         bit_count <= next_bit_count;
      end
   end

   // ------------------------------------------------------------
   // Link domain: serial input register
   // ------------------------------------------------------------
   // falling edge shift
   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
      begin
         serial_input_register <= WORD_RESET;
      end
      else if (shift_en)
      begin
         serial_input_register <= {serial_input_register[WORD_BITS-2:0], sdi};
      end
   end

   // ------------------------------------------------------------
   // Link domain: internal end of frame
   // ------------------------------------------------------------
   // sixteenth clock event
   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
      begin
         term_toggle <= 1'b0;
      end
      else if (shift_en && term_en && (next_bit_count == WORD_LEN))
      begin
         term_toggle <= ~term_toggle;
      end
   end

   // ------------------------------------------------------------
   // Crossing into the system clock
   // ------------------------------------------------------------
   sync2
   #(
      .WIDTH(2),
      .RESET_VALUE(2'h2)
   )
   u_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in({cs_n, term_toggle}),
      .sync_out({cs_sync, toggle_sync})
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cs_prev <= 1'b1;
         toggle_prev <= 1'b0;
      end
      else
      begin
         cs_prev <= cs_sync;
         toggle_prev <= toggle_sync;
      end
   end

   assign cs_rise = cs_sync & ~cs_prev;
   assign cs_fall = ~cs_sync & cs_prev;
   assign term_event = toggle_sync ^ toggle_prev;

   // ------------------------------------------------------------
   // Frame state
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      end_event = 1'b0;
      case (state)
         FRAME_IDLE:
         begin
            if (cs_fall)
            begin
               next_state = FRAME_OPEN;
            end
         end
         FRAME_OPEN:
         begin
            if (cs_rise)
            begin
               next_state = FRAME_IDLE;
               end_event = 1'b1;
            end
            else if (term_event)
            begin
               next_state = FRAME_ENDED;
               end_event = 1'b1;
            end
         end
         FRAME_ENDED:
         begin
            if (cs_rise)
            begin
               next_state = FRAME_IDLE;
            end
         end
         default:
         begin
            next_state = FRAME_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= FRAME_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Word capture
   // ------------------------------------------------------------
   // The shift register is read across domains only after the end of the
   // frame has passed the synchroniser; by then no serial edge can move it.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         word_q <= WORD_RESET;
         count_q <= COUNT_ZERO;
      end
      else if (end_event)
      begin
         word_q <= serial_input_register;
         count_q <= bit_count;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         issue <= 1'b0;
      end
      else
      begin
         issue <= end_event;
      end
   end

   assign upd.strobe = issue;
   assign upd.word = word_q;

   // ------------------------------------------------------------
   // Latches
   // ------------------------------------------------------------
   dac_latch_bank u_bank
   (
      .clk(clk),
      .rst(rst),
      .upd(upd),
      .latch_a(latch_a),
      .latch_b(latch_b),
      .dbuf(dbuf)
   );

   assign dac_a_code = latch_a[CODE_MSB:CODE_LSB];
   assign dac_b_code = latch_b[CODE_MSB:CODE_LSB];
   assign buffer_code = dbuf[CODE_MSB:CODE_LSB];

   // ------------------------------------------------------------
   // Mode and status
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         slow_mode <= 1'b0;
         power_down <= 1'b0;
         length_error <= 1'b0;
         last_word <= WORD_RESET;
      end
      else if (issue)
      begin
         slow_mode <= word_q[BIT_SPEED];
         power_down <= word_q[BIT_POWER_DOWN];
         length_error <= (count_q != WORD_LEN);
         last_word <= word_q;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         update_done <= 1'b0;
      end
      else
      begin
         update_done <= issue;
      end
   end

   // ------------------------------------------------------------
   // Settling timers
   // ------------------------------------------------------------
   // Only a loaded latch restarts its timer; a copy of an unchanged buffer
   // into latch B still restarts B, which errs on the safe side.
   assign load_ch = {upd.load_b, upd.load_a};

   for (genvar ch = 0; ch < DAC_COUNT; ch++)
   begin : g_settle
      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            settle_cnt[ch] <= SETTLE_ZERO;
         end
         else if (load_ch[ch])
         begin
            settle_cnt[ch] <= upd.word[BIT_SPEED] ? SETTLE_SLOW_CYCLES : SETTLE_FAST_CYCLES;
         end
         else if (settle_cnt[ch] != SETTLE_ZERO)
         begin
            settle_cnt[ch] <= settle_cnt[ch] - SETTLE_STEP;
         end
      end
   end

   assign settling_a = (settle_cnt[0] != SETTLE_ZERO);
   assign settling_b = (settle_cnt[1] != SETTLE_ZERO);
endmodule

// *** verification/dac_ctrl_monitor.sv ***
// Concurrent checks on the ports of the dual DAC serial front end.
`timescale 1ns/1ns
module dac_ctrl_monitor
   import dac_ctrl_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst,
   // Serial link and configuration
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic self_terminate,
   // DAC drive
   input wire logic [CODE_BITS-1:0] dac_a_code,
   input wire logic [CODE_BITS-1:0] dac_b_code,
   input wire logic [CODE_BITS-1:0] buffer_code,
   input wire logic slow_mode,
   input wire logic power_down,
   // Status
   input wire logic settling_a,
   input wire logic settling_b,
   input wire logic update_done,
   input wire logic length_error,
   input wire logic [WORD_BITS-1:0] last_word
);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_reset_zero: assert property ($fell(rst) |-> dac_a_code == 10'h000 && dac_b_code == 10'h000)
      else $error("codes not zero after reset");
   chk_a_holds: assert property (!update_done |-> $stable(dac_a_code))
      else $error("dac a changed without update");
   chk_b_holds: assert property (!update_done |-> $stable(dac_b_code) && $stable(buffer_code))
      else $error("dac b or buffer changed without update");
   chk_a_write_copy: assert property (update_done && last_word[15] |->
      dac_a_code == last_word[11:2] && dac_b_code == buffer_code && $stable(buffer_code))
      else $error("latch a write wrong");
   chk_b_write: assert property (update_done && !last_word[15] && !last_word[12] |->
      dac_b_code == last_word[11:2] && buffer_code == last_word[11:2] && $stable(dac_a_code))
      else $error("latch b write wrong");
   chk_dbuf_only: assert property (update_done && !last_word[15] && last_word[12] |->
      buffer_code == last_word[11:2] && $stable(dac_a_code) && $stable(dac_b_code))
      else $error("buffer only write wrong");
   chk_mode_bits: assert property (update_done |-> slow_mode == last_word[14] && power_down == last_word[13])
      else $error("mode bits wrong");
   chk_done_pulse: assert property (update_done |=> !update_done)
      else $error("update pulse too long");
   chk_settle_start: assert property (update_done && last_word[15] |-> settling_a && settling_b)
      else $error("settling not started");
   chk_fast_settle: assert property ($rose(settling_b) && !slow_mode |-> ##[248:252] !settling_b)
      else $error("fast settling length wrong");
   chk_fast_settle_a: assert property ($rose(settling_a) && !slow_mode |-> ##[248:252] !settling_a)
      else $error("fast settling length wrong on dac a");
endmodule
bind dual_dac_serial_latch_control dac_ctrl_monitor u_mon (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
   .sdi(sdi), .self_terminate(self_terminate), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
   .buffer_code(buffer_code), .slow_mode(slow_mode), .power_down(power_down), .settling_a(settling_a),
   .settling_b(settling_b), .update_done(update_done), .length_error(length_error), .last_word(last_word));

// *** verification/host_serial_model.sv ***
// Host serial port model that frames words onto clock, select and data.
`timescale 1ns/1ns
module host_serial_model
(
   // Serial link
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   // ------------------------------------------------------------
   // Frame driver
   // ------------------------------------------------------------
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // 160 ns period, 80 ns phases.
   task automatic bit_out(input logic b);
      sdi = b;
      #40;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
      #40;
   endtask
   // Junk bits are the inverse of the last level so a stale value never passes for data.
   task automatic send(input logic [15:0] w, input int lead, input int trail);
      #3;
      // select falls with the clock low.
      cs_n = 1'b0;
      #40;
      repeat (lead) bit_out(~sdi);
      for (int i = 15; i >= 0; i--)
         bit_out(w[i]);
      repeat (trail) bit_out(~sdi);
      #40;
      // select rises with the clock low.
      cs_n = 1'b1;
      sdi = ~sdi;
      // frames at least 1000 ns apart.
      #1000;
   endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the dual DAC serial front end.
`timescale 1ns/1ns
module testbench;
   import dac_ctrl_pkg::*;
   logic clk, rst, sclk, cs_n, sdi, self_terminate;
   logic [CODE_BITS-1:0] dac_a_code, dac_b_code, buffer_code;
   logic slow_mode, power_down, settling_a, settling_b, update_done, length_error;
   logic [WORD_BITS-1:0] last_word, exp_w;
   logic [11:0] exp_a, exp_b, exp_d;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [15:0] corner [5] = '{16'h1ffc, 16'h8800, 16'h8000, 16'h0ffc, 16'h6004};
   // ------------------------------------------------------------
   // Instances and clock
   // ------------------------------------------------------------
   host_serial_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   dual_dac_serial_latch_control u_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .self_terminate(self_terminate), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
      .buffer_code(buffer_code), .slow_mode(slow_mode), .power_down(power_down), .settling_a(settling_a),
      .settling_b(settling_b), .update_done(update_done), .length_error(length_error), .last_word(last_word));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Expectation and checking
   // ------------------------------------------------------------
   function automatic logic [35:0] next_latches(input logic [35:0] cur, input logic [15:0] w);
      logic [11:0] a, b, d;
      {a, b, d} = cur;
      if (w[15])
      begin
         a = w[11:0];
         b = d;
      end
      else if (!w[12])
      begin
         b = w[11:0];
         d = w[11:0];
      end
      else
         d = w[11:0];
      return {a, b, d};
   endfunction
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask
   task automatic check_all(input logic lerr);
      check("dac_a_code", 16'(exp_a[11:2]), 16'(dac_a_code));
      check("dac_b_code", 16'(exp_b[11:2]), 16'(dac_b_code));
      check("buffer_code", 16'(exp_d[11:2]), 16'(buffer_code));
      check("slow_mode", 16'(exp_w[14]), 16'(slow_mode));
      check("power_down", 16'(exp_w[13]), 16'(power_down));
      check("last_word", exp_w, last_word);
      check("length_error", 16'(lerr), 16'(length_error));
   endtask
   task automatic frame(input logic [15:0] w, input int lead, input int trail, input logic lerr);
      int k;
      k = 0;
      fork
         u_host.send(w, lead, trail);
         while (update_done !== 1'b1 && k < 700)
         begin
            @(posedge clk);
            #1;
            k++;
         end
      join
      check("update_done", 16'h0001, 16'(k < 700));
      {exp_a, exp_b, exp_d} = next_latches({exp_a, exp_b, exp_d}, w);
      exp_w = w;
      check_all(lerr);
   endtask
   task automatic conclude();
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // The ceiling sits well above the longest expected run of frames.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_fail++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      self_terminate = 1'b0;
      exp_a = 12'h000;
      exp_b = 12'h000;
      exp_d = 12'h000;
      exp_w = 16'h0000;
      void'($urandom(8));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check_all(1'b0);
      foreach (corner[i])
         frame(corner[i], 0, 0, 1'b0);
      for (int i = 0; i < 12; i++)
         frame(16'($urandom), 0, 0, 1'b0);
      // A second reset in mid-run must clear every latch and status bit again.
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      {exp_a, exp_b, exp_d} = 36'h000000000;
      exp_w = 16'h0000;
      repeat (3) @(posedge clk);
      #1;
      check_all(1'b0);
      frame(16'($urandom), 1, 0, 1'b1);
      @(posedge clk);
      self_terminate <= 1'b1;
      frame(16'h0ffc, 0, 0, 1'b0);
      frame(16'($urandom), 0, 4, 1'b0);
      frame(16'($urandom), 0, 3, 1'b0);
      conclude();
   end
endmodule
